/* inc/srd_if.sv */
// Two-wire link between the bus master and the memory slave
`timescale 1ns/1ps
`default_nettype none
interface srd_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    wire  sda;

    // Open drain with pull-up: any enabled low driver wins
    assign sda = ((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o)) ? 1'b0
                                                                : 1'b1;

    modport master (output scl, output m_sda_o, output m_sda_oe,
                    input sda);
    modport device (input scl, input sda, output d_sda_o,
                    output d_sda_oe);
endinterface
`default_nettype wire

/* inc/srd_params.svh */
// Constants shared by both ends of the serial memory read link
`ifndef SRD_PARAMS_SVH
`define SRD_PARAMS_SVH

`define SRD_CLK_MHZ      50
`define SRD_WR_TIME_US   4000
`define SRD_QTR_CYC      5
// Arbitrary device-type code, not a real part's value
`define SRD_TYPE_CODE    4'h6
`define SRD_MEM_DEPTH    16
`define SRD_ADDR_W       4
`define SRD_DATA_W       8
`define SRD_FIFO_DEPTH   16
`define SRD_BITS         4'h8
`define SRD_RW_BIT       0
`define SRD_CODE_MSB     7
`define SRD_CODE_LSB     4

`endif

/* inc/srd_pkg.sv */
// Types shared by both ends of the serial memory read link
package srd_pkg;

    typedef enum logic [3:0] {
        D_IDLE = 4'h0,
        D_CTRL = 4'h1,
        D_CACK = 4'h2,
        D_ADDR = 4'h3,
        D_AACK = 4'h4,
        D_WDAT = 4'h5,
        D_WACK = 4'h6,
        D_RDAT = 4'h7,
        D_RACK = 4'h8
    } srd_dstate_t;

    typedef enum logic [2:0] {
        M_IDLE  = 3'h0,
        M_START = 3'h1,
        M_TX    = 3'h2,
        M_RX    = 3'h3,
        M_STOP  = 3'h4
    } srd_mstate_t;

    typedef enum logic [1:0] {
        CMD_CUR   = 2'h0,
        CMD_RAND  = 2'h1,
        CMD_WRITE = 2'h2
    } srd_cmd_t;

    typedef enum logic [2:0] {
        ST_CTRLW = 3'h0,
        ST_ADDR  = 3'h1,
        ST_DATA  = 3'h2,
        ST_CTRLR = 3'h3
    } srd_step_t;

endpackage

/* rtl/srd_device.sv */
// Memory slave end: control byte decode, pointer, reads and byte write
// Function
// R1: Read starts like write, R/W bit one
// R2: Counter holds last address plus one; after a byte write it holds the written address
// R3: Matching read control byte acked, data shifted
// R4: Master nack then stop; device stops driving
// R5: Master loads address with write-type byte
// R6: Repeated start aborts write, keeps address
// R7: Master resends control byte with read bit
// R8: After random read, pointer at next byte
// R9: Master ack requests next consecutive byte
// R10: Pointer increments after each read byte
// R11: Ack only matching 4-bit type code
// R12: Only low four address bits used
// R13: No ack during internal write cycle
// R14: Data changes only while clock low
// R15: Pointer wraps from top to zero
`include "srd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module srd_device
    import srd_pkg::*;
#(
    parameter int         WR_CYCLES = `SRD_WR_TIME_US * `SRD_CLK_MHZ,
    // Arbitrary type code
    parameter logic [3:0] TYPE_CODE = `SRD_TYPE_CODE
)
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    ce,
    srd_if.device                        bus,
    input  wire logic                    init_we,
    input  wire logic [`SRD_ADDR_W-1:0]  init_addr,
    input  wire logic [`SRD_DATA_W-1:0]  init_data,
    output logic                         busy,
    output logic [`SRD_ADDR_W-1:0]       ptr
);

    localparam logic [17:0] WR_LOAD = 18'(WR_CYCLES - 1);

    logic [`SRD_DATA_W-1:0] mem_r [`SRD_MEM_DEPTH];
    srd_dstate_t            state_r, state_nxt;
    logic [3:0]             cnt_r, cnt_nxt;
    logic [7:0]             sh_r, sh_nxt;
    logic [7:0]             tx_r, tx_nxt;
    logic [7:0]             wdat_r, wdat_nxt;
    logic [3:0]             ptr_r, ptr_nxt;
    logic                   oe_r, oe_nxt;
    logic                   pend_r, pend_nxt;
    logic                   rw_r, rw_nxt;
    logic                   mack_r, mack_nxt;
    logic [17:0]            bcnt_r, bcnt_nxt;
    logic                   busy_r;
    logic                   scl_s1, scl_s2, scl_s3;
    logic                   sda_s1, sda_s2, sda_s3;

    // Second and third stages feed the edge logic; first stage only feeds the second
    wire rise_w  = scl_s2 & ~scl_s3;
    wire fall_w  = ~scl_s2 & scl_s3;
    wire scl_hi  = scl_s2 & scl_s3;
    wire start_w = scl_hi & sda_s3 & ~sda_s2;
    wire stop_w  = scl_hi & ~sda_s3 & sda_s2;
    wire full_w  = (cnt_r == `SRD_BITS);
    wire match_w = (sh_r[`SRD_CODE_MSB:`SRD_CODE_LSB] == TYPE_CODE);
    wire commit_w = stop_w & pend_r;
    wire [7:0] cur_byte = mem_r[ptr_r];

    assign bus.d_sda_o  = 1'b0;
    assign bus.d_sda_oe = oe_r;
    assign busy         = busy_r;
    assign ptr          = ptr_r;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end
        else if (ce)
        begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        tx_nxt    = tx_r;
        wdat_nxt  = wdat_r;
        ptr_nxt   = ptr_r;
        oe_nxt    = oe_r;
        pend_nxt  = pend_r;
        rw_nxt    = rw_r;
        mack_nxt  = mack_r;
        bcnt_nxt  = (bcnt_r != 18'h00000) ? bcnt_r - 18'h00001 : bcnt_r;
        if (commit_w)
            bcnt_nxt = WR_LOAD;
        if (start_w)
        begin
            // Repeated start drops pending data, keeps pointer
            state_nxt = D_CTRL; // R1 R6
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            pend_nxt  = 1'b0; // R6
        end
        else if (stop_w)
        begin
            state_nxt = D_IDLE;
            oe_nxt    = 1'b0; // R4
            pend_nxt  = 1'b0;
        end
        else if (rise_w)
        begin
            case (state_r)
                D_CTRL, D_ADDR, D_WDAT:
                begin
                    if (!full_w)
                    begin
                        sh_nxt  = {sh_r[6:0], sda_s2};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                D_RACK:  mack_nxt = ~sda_s2; // R9
                default: mack_nxt = mack_r;
            endcase
        end
        else if (fall_w)
        begin
            // Drive changes other than the release on a start or stop follow a falling clock edge
            case (state_r) // R14
                D_CTRL:
                begin
                    if (full_w)
                    begin
                        if (match_w && !busy_r) // R11 R13
                        begin
                            oe_nxt    = 1'b1; // R3
                            state_nxt = D_CACK;
                            rw_nxt    = sh_r[`SRD_RW_BIT]; // R1
                        end
                        else
                            state_nxt = D_IDLE;
                    end
                end
                D_CACK:
                begin
                    if (rw_r)
                    begin
                        tx_nxt    = {cur_byte[6:0], 1'b0}; // R2 R3
                        oe_nxt    = ~cur_byte[7];
                        cnt_nxt   = 4'h1;
                        state_nxt = D_RDAT;
                    end
                    else
                    begin
                        oe_nxt    = 1'b0;
                        cnt_nxt   = 4'h0;
                        state_nxt = D_ADDR;
                    end
                end
                D_ADDR:
                begin
                    if (full_w)
                    begin
                        ptr_nxt   = sh_r[`SRD_ADDR_W-1:0]; // R12 R6
                        oe_nxt    = 1'b1;
                        state_nxt = D_AACK;
                    end
                end
                D_WDAT:
                begin
                    if (full_w)
                    begin
                        // Extra bytes overwrite the held one
                        wdat_nxt  = sh_r;
                        pend_nxt  = 1'b1;
                        oe_nxt    = 1'b1;
                        state_nxt = D_WACK;
                    end
                end
                D_AACK, D_WACK:
                begin
                    oe_nxt    = 1'b0;
                    cnt_nxt   = 4'h0;
                    state_nxt = D_WDAT;
                end
                D_RDAT:
                begin
                    if (full_w)
                    begin
                        // Release for master ack; step past this byte
                        oe_nxt    = 1'b0;
                        ptr_nxt   = ptr_r + 4'h1; // R10 R8 R15
                        mack_nxt  = 1'b0;
                        state_nxt = D_RACK;
                    end
                    else
                    begin
                        oe_nxt  = ~tx_r[7];
                        tx_nxt  = {tx_r[6:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                D_RACK:
                begin
                    if (mack_r)
                    begin
                        tx_nxt    = {cur_byte[6:0], 1'b0}; // R9
                        oe_nxt    = ~cur_byte[7];
                        cnt_nxt   = 4'h1;
                        state_nxt = D_RDAT;
                    end
                    else
                        state_nxt = D_IDLE; // R4
                end
                default: state_nxt = D_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= D_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            tx_r    <= 8'h00;
            wdat_r  <= 8'h00;
            ptr_r   <= 4'h0;
            oe_r    <= 1'b0;
            pend_r  <= 1'b0;
            rw_r    <= 1'b0;
            mack_r  <= 1'b0;
            bcnt_r  <= 18'h00000;
            busy_r  <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            tx_r    <= tx_nxt;
            wdat_r  <= wdat_nxt;
            ptr_r   <= ptr_nxt;
            oe_r    <= oe_nxt;
            pend_r  <= pend_nxt;
            rw_r    <= rw_nxt;
            mack_r  <= mack_nxt;
            bcnt_r  <= bcnt_nxt;
            busy_r  <= (bcnt_nxt != 18'h00000); // R13
        end
    end

    // Byte write lands at the pointer; pointer is not advanced
    always_ff @(posedge ref_clk)
    begin
        if (ce && commit_w)
            mem_r[ptr_r] <= wdat_r;
        else if (ce && init_we)
            mem_r[init_addr] <= init_data;
    end

endmodule
`default_nettype wire

/* rtl/srd_master.sv */
// Bus master end: clock divider, byte sequencer and read-data FIFO
`include "srd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module srd_fifo #(
    parameter int W = 8,
    parameter int D = 16
)
(
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;

    wire push_w = in_valid & in_ready & ce;
    wire pop_w  = out_valid & out_ready & ce;

    assign in_ready  = ~((wp_r[AW] != rp_r[AW]) &&
                         (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign out_valid = (wp_r != rp_r);
    assign out_data  = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (push_w)
                wp_r <= wp_r + 1'b1;
            if (pop_w)
                rp_r <= rp_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push_w)
            mem_r[wp_r[AW-1:0]] <= in_data;
    end
endmodule

module srd_master
    import srd_pkg::*;
#(
    // Arbitrary type code
    parameter logic [3:0] TYPE_CODE = `SRD_TYPE_CODE
)
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    srd_if.master            bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [1:0]  cmd_kind,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    input  wire logic [4:0]  cmd_len,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [7:0]       rd_data,
    output logic             done,
    output logic             nack
);
    localparam logic [2:0] QTR = 3'(`SRD_QTR_CYC - 1);

    srd_mstate_t state_r;
    srd_step_t   step_r;
    srd_cmd_t    kind_r;
    logic [2:0]  q_r;
    logic [1:0]  ph_r;
    logic [3:0]  bit_r;
    logic [7:0]  tx_r, rx_r, addr_r, wdat_r;
    logic [4:0]  left_r;
    logic        scl_r, oe_r, ack_r, done_r, nack_r, rdy_r;
    logic        sda_s1, sda_s2;
    logic        f_ready;

    wire tick_w  = (q_r == QTR);
    wire last_w  = (bit_r == `SRD_BITS);
    wire hold_w  = (state_r == M_RX) && last_w && (ph_r == 2'h0);
    // Full FIFO keeps SCL low before the ack bit
    wire stall_w = hold_w & ~f_ready;
    wire push_w  = hold_w & tick_w & ce;
    wire more_w  = (left_r > 5'h01);

    function automatic logic [7:0] ctrl_byte(input logic rd);
        ctrl_byte = {TYPE_CODE, 3'b000, rd};
    endfunction

    assign bus.scl      = scl_r;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = oe_r;
    assign cmd_ready    = rdy_r;
    assign done         = done_r;
    assign nack         = nack_r;

    srd_fifo #(.W(`SRD_DATA_W), .D(`SRD_FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (push_w),
        .in_ready  (f_ready),
        .in_data   (rx_r),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end
        else if (ce)
        begin
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r <= M_IDLE;
            step_r  <= ST_CTRLW;
            kind_r  <= CMD_CUR;
            q_r     <= 3'h0;
            ph_r    <= 2'h0;
            bit_r   <= 4'h0;
            tx_r    <= 8'h00;
            rx_r    <= 8'h00;
            addr_r  <= 8'h00;
            wdat_r  <= 8'h00;
            left_r  <= 5'h00;
            scl_r   <= 1'b1;
            oe_r    <= 1'b0;
            ack_r   <= 1'b0;
            done_r  <= 1'b0;
            nack_r  <= 1'b0;
            rdy_r   <= 1'b0;
        end
        else if (ce)
        begin
            done_r <= 1'b0;
            rdy_r  <= (state_r == M_IDLE) && !(cmd_valid && rdy_r);
            q_r    <= (tick_w || state_r == M_IDLE) ? 3'h0 : q_r + 3'h1;
            if (state_r == M_IDLE)
            begin
                if (cmd_valid && rdy_r)
                begin
                    kind_r  <= srd_cmd_t'(cmd_kind);
                    addr_r  <= cmd_addr;
                    wdat_r  <= cmd_wdata;
                    left_r  <= (cmd_len == 5'h00) ? 5'h01 : cmd_len;
                    step_r  <= (cmd_kind == CMD_CUR) ? ST_CTRLR : ST_CTRLW;
                    nack_r  <= 1'b0;
                    ph_r    <= 2'h0;
                    state_r <= M_START;
                end
            end
            else if (tick_w && !stall_w)
            begin
                ph_r <= ph_r + 2'h1;
                case (ph_r)
                    2'h0: // R14
                    begin
                        if (state_r == M_START)
                            oe_r <= 1'b0;
                        else if (state_r == M_STOP)
                            oe_r <= 1'b1;
                        else if (state_r == M_TX)
                            oe_r <= last_w ? 1'b0 : ~tx_r[7];
                        else
                            oe_r <= last_w & more_w; // R4 R9
                    end
                    2'h1: scl_r <= 1'b1;
                    2'h2:
                    begin
                        if (state_r == M_START)
                            oe_r <= 1'b1;
                        else if (state_r == M_STOP)
                            oe_r <= 1'b0;
                        else if (state_r == M_TX && last_w)
                            ack_r <= ~sda_s2;
                        else if (state_r == M_RX && !last_w)
                            rx_r <= {rx_r[6:0], sda_s2};
                    end
                    default:
                    begin
                        if (state_r != M_STOP)
                            scl_r <= 1'b0;
                        bit_r <= last_w ? 4'h0 : bit_r + 4'h1;
                        tx_r  <= {tx_r[6:0], 1'b0};
                        case (state_r)
                            M_START:
                            begin
                                tx_r    <= ctrl_byte(step_r == ST_CTRLR);
                                bit_r   <= 4'h0;
                                state_r <= M_TX;
                            end
                            M_TX:
                            begin
                                if (last_w && !ack_r)
                                begin
                                    nack_r  <= 1'b1;
                                    state_r <= M_STOP;
                                end
                                else if (last_w)
                                begin
                                    case (step_r)
                                        ST_CTRLW:
                                        begin
                                            tx_r   <= addr_r; // R5
                                            step_r <= ST_ADDR;
                                        end
                                        ST_ADDR:
                                        begin
                                            tx_r   <= wdat_r;
                                            step_r <= (kind_r == CMD_WRITE)
                                                      ? ST_DATA : ST_CTRLR;
                                            if (kind_r != CMD_WRITE)
                                                state_r <= M_START; // R7
                                        end
                                        ST_CTRLR: state_r <= M_RX;
                                        default:  state_r <= M_STOP;
                                    endcase
                                end
                            end
                            M_RX:
                            begin
                                if (last_w)
                                begin
                                    left_r  <= left_r - 5'h01;
                                    state_r <= more_w ? M_RX : M_STOP;
                                end
                            end
                            M_STOP:
                            begin
                                done_r  <= 1'b1;
                                state_r <= M_IDLE;
                            end
                            default: state_r <= M_IDLE;
                        endcase
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* sim/serial_eeprom_read_engine_test.sv */
// Self-checking bench joining the master and the memory slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_engine_test;
    import srd_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, rd_ready = 1'b0;
    logic init_we = 1'b0;
    logic [3:0] init_addr = 4'h0;
    logic [7:0] init_data = 8'h00, cmd_addr = 8'h00, cmd_wdata = 8'h00;
    logic [1:0] cmd_kind = 2'h0;
    logic [4:0] cmd_len = 5'h01;
    logic cmd_ready, rd_valid, done, nack, busy;
    logic [7:0] rd_data;
    logic [3:0] ptr;
    logic [7:0] mem_e [16];
    int num_errors = 0, samples_checked = 0;

    always #10 ref_clk = ~ref_clk;

    srd_if lnk ();
    srd_master u_srd_master (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
        .bus(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .done(done), .nack(nack));
    // Long enough that a read command lands inside the write cycle
    srd_device #(.WR_CYCLES(2000)) u_srd_device (.ref_clk(ref_clk),
        .reset(reset), .ce(1'b1), .bus(lnk), .init_we(init_we),
        .init_addr(init_addr), .init_data(init_data), .busy(busy),
        .ptr(ptr));
    srd_link_props u_srd_link_props (.ref_clk(ref_clk), .reset(reset),
        .scl(lnk.scl), .m_sda_o(lnk.m_sda_o), .m_sda_oe(lnk.m_sda_oe),
        .d_sda_o(lnk.d_sda_o), .d_sda_oe(lnk.d_sda_oe), .sda(lnk.sda));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic run(input logic [1:0] k, input logic [7:0] a,
                       input logic [4:0] n);
        int t;
        t = 0;
        while (cmd_ready !== 1'b1 && t < 500)
        begin
            @(negedge ref_clk);
            t++;
        end
        chk_bit(cmd_ready, 1'b1);
        cmd_kind = k;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 20000)
        begin
            @(negedge ref_clk);
            t++;
        end
        chk_bit(done, 1'b1);
        @(negedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic pop(input logic [7:0] e);
        chk_bit(rd_valid, 1'b1);
        chk_byte(rd_data, e);
        rd_ready = 1'b1;
        @(negedge ref_clk);
        rd_ready = 1'b0;
        // Idle cycle so back-to-back pops never retoggle in one step
        @(negedge ref_clk);
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end

    initial
    begin
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            mem_e[i] = 8'hC3 ^ 8'(i * 17);
            init_we = 1'b1;
            init_addr = 4'(i);
            init_data = mem_e[i];
            @(negedge ref_clk);
        end
        init_we = 1'b0;
        run(CMD_RAND, 8'hF3, 5'h01);
        pop(mem_e[3]);
        chk_byte({4'h0, ptr}, 8'h04);
        run(CMD_CUR, 8'h00, 5'h01);
        pop(mem_e[4]);
        chk_bit(nack, 1'b0);
        run(CMD_RAND, 8'h0E, 5'h04);
        pop(mem_e[14]);
        pop(mem_e[15]);
        pop(mem_e[0]);
        chk_byte({4'h0, ptr}, 8'h02);
        // One byte left queued, so the sweep overfills the buffer
        fork
            run(CMD_RAND, 8'h00, 5'h10);
            begin
                repeat (4000) @(negedge ref_clk);
                chk_bit(lnk.scl, 1'b0);
                pop(mem_e[1]);
                for (int i = 0; i < 16; i++)
                    pop(mem_e[i]);
            end
        join
        chk_bit(rd_valid, 1'b0);
        chk_byte({4'h0, ptr}, 8'h00);
        cmd_wdata = 8'h5A;
        mem_e[5] = 8'h5A;
        run(CMD_WRITE, 8'h05, 5'h01);
        chk_bit(nack, 1'b0);
        chk_bit(busy, 1'b1);
        run(CMD_CUR, 8'h00, 5'h01);
        chk_bit(nack, 1'b1);
        chk_byte({4'h0, ptr}, 8'h05);
        for (int t = 0; t < 5000 && busy === 1'b1; t++)
            @(negedge ref_clk);
        chk_bit(busy, 1'b0);
        run(CMD_CUR, 8'h00, 5'h01);
        pop(mem_e[5]);
        chk_byte({4'h0, ptr}, 8'h06);
        summarize();
    end
endmodule
`default_nettype wire

/* sim/srd_link_props.sv */
// Checker of the two-wire lines between the master and the memory slave
`timescale 1ns/1ps
`default_nettype none
module srd_link_props
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Data edges with the clock high mark frame boundaries
    sequence stop_seq;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence start_seq;
        scl && $past(scl) && $fell(sda);
    endsequence

    AST_STOP_RELEASE: assert property (stop_seq |=> !d_sda_oe [*8])
        else $error("slave drives data after a stop");
    AST_START_MASTER: assert property (start_seq |-> m_sda_oe && !d_sda_oe)
        else $error("start not made by the master alone");
    AST_DEV_HOLD_HIGH: assert property ((scl && $past(scl)) |-> $stable(d_sda_oe))
        else $error("slave data moved while clock high");
    AST_DEV_TURN_LOW: assert property (($rose(d_sda_oe) || $fell(d_sda_oe))
        |-> !scl && !$past(scl))
        else $error("slave data turned near a clock high");
    AST_SCL_HIGH_LEN: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    AST_SCL_LOW_LEN: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    AST_NO_FIGHT: assert property (scl |-> !(m_sda_oe && d_sda_oe))
        else $error("both ends drive data while clock high");
    AST_OPEN_DRAIN: assert property (d_sda_oe |-> !d_sda_o)
        else $error("slave drives data high");
    AST_RESET_IDLE: assert property ($fell(reset)
        |-> scl && !m_sda_oe && !d_sda_oe)
        else $error("link not idle after reset");
endmodule
`default_nettype wire
